// *** inc/pin_mode_pkg.sv ***
// Constants and types for the reset and mode pin control block
package pin_mode_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_SYSTEM_OPTIONS_ONE     = 8'h00;
   localparam logic [7:0] OFS_DEBUG_FORCE_RESET_REG  = 8'h04;
   localparam logic [7:0] OFS_CLOCK_CTRL_REG_TWO     = 8'h08;
   localparam logic [7:0] OFS_MODE_STATUS            = 8'h0C;
   // Field positions
   localparam int BIT_RESET_PIN_SELECT   = 0;
   localparam int BIT_DEBUG_PIN_SELECT   = 1;
   localparam int BIT_DEBUG_FORCE_RESET  = 0;
   localparam int BIT_OSC_RANGE          = 0;
   localparam int BIT_OSC_EXT_CLOCK      = 1;
   localparam int BIT_BUS_DIV_LO         = 2;
   localparam int BIT_STAT_HALTED        = 0;
   localparam int BIT_STAT_RESET_PIN     = 1;
   localparam int BIT_STAT_CAUSE_LO      = 2;
   // Clocking: internal source and default bus clock
   localparam int ICS_NOMINAL_MHZ        = 16;
   localparam int BUS_DEFAULT_MHZ        = 8;
   localparam logic [1:0] BUS_DIV_DEFAULT = 2'(ICS_NOMINAL_MHZ / BUS_DEFAULT_MHZ - 1);
   // Values after reset
   localparam logic RESET_PIN_SELECT_RST = 1'b0;
   localparam logic DEBUG_PIN_SELECT_RST = 1'b1;
   localparam logic OSC_RANGE_RST        = 1'b0;
   localparam logic OSC_EXT_CLOCK_RST    = 1'b0;
   // Cycle counts
   localparam logic [3:0] RESET_HOLD_CYCLES = 4'h8;
   localparam logic [4:0] BIT_CYCLES        = 5'h10;
   localparam logic [4:0] LOW_CYCLES_ONE    = 5'h04;
   localparam logic [4:0] LOW_CYCLES_ZERO   = 5'h0D;

   typedef enum logic [1:0] {cause_por, cause_pin, cause_force} cause_type;
   typedef enum logic [1:0] {tx_idle, tx_low, tx_speedup, tx_release} tx_state_type;

   typedef struct packed {
      logic         rst_s1;
      logic         rst_s2;
      logic         ms_s1;
      logic         ms_s2;
      logic         reset_pin_select;
      logic         debug_pin_select;
      logic         osc_range;
      logic         osc_ext_clock;
      logic [1:0]   bus_div;
      logic         in_reset;
      logic [3:0]   hold_cnt;
      cause_type    cause;
      logic         halted;
      logic         sys_reset_n;
      logic         rst_pin_pullup;
      logic         dbg_pin_pullup;
      logic         alt_fn_enable;
      tx_state_type tx_state;
      logic [4:0]   bit_cnt;
      logic [4:0]   low_len;
      logic         dbg_out;
      logic         dbg_oe;
      logic         tx_busy;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
   } state_type;
endpackage : pin_mode_pkg

// *** core/reset_and_mode_pin_control.sv ***
// Reset pin, debug/mode pin and clock option control with an APB register slave
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns
// Operation
// - All software registers of this block are clocked by the bus clock pclk.
// - Out of reset the clock selects the 16 MHz internal source divided to an 8 MHz bus.
// - A range bit picks one of two resonator ranges and another bit selects an external clock.
// - After power-on reset the shared reset pin is a plain port input.
// - Setting the reset pin select bit makes the pin the reset input until the next power-on.
// - A low level on the enabled reset pin resets the device and its pullup is switched on.
// - A reset from the reset pin always comes up in user mode, never halted.
// - Halted debug is entered on a low mode pin at power-on or at a software debug force reset.
// - During power-on or debug force reset the debug pin is only an input for mode select.
// - After any reset the debug pin serves debug traffic with pullup on while selected.
// - Every reset sets the debug pin select bit; software clears it for other functions.
// - A floating, pulled-up mode pin gives normal mode when the internal reset rises.
// - Each bit time on the debug wire lasts 16 debug controller clocks.
// - The debug controller clock may be as fast as the fastest bus clock.
// - The debug pin is pseudo open-drain with short actively driven high speedup pulses.
module reset_and_mode_pin_control (
   // Bus clock and power-on reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Shared reset pin
   input  wire logic        reset_pin_in,
   output logic             reset_pin_pullup,
   // Shared debug and mode select pin
   input  wire logic        debug_pin_in,
   output logic             debug_pin_out,
   output logic             debug_pin_oe,
   output logic             debug_pin_pullup,
   output logic             port_a_bit_four_alt_enable,
   // Debug controller bit transmit
   input  wire logic        dbg_tx_start,
   input  wire logic        dbg_tx_bit,
   output logic             dbg_tx_busy,
   // System reset, mode and clock choices
   output logic             sys_reset_n,
   output logic             halted_debug_state,
   output logic             osc_range,
   output logic             osc_ext_clock,
   output logic [1:0]       bus_div
);
   pin_mode_pkg::state_type q;
   pin_mode_pkg::state_type d;

   logic setup;
   logic wr_take;
   logic mapped;
   logic [7:0] ofs;

   assign setup   = psel && !penable;
   assign wr_take = psel && penable && q.pready && pwrite && !q.in_reset;
   assign ofs     = paddr;
   assign mapped  = (ofs == pin_mode_pkg::OFS_SYSTEM_OPTIONS_ONE) ||
                    (ofs == pin_mode_pkg::OFS_DEBUG_FORCE_RESET_REG) ||
                    (ofs == pin_mode_pkg::OFS_CLOCK_CTRL_REG_TWO) ||
                    (ofs == pin_mode_pkg::OFS_MODE_STATUS);

   always_comb begin
      d = q;
      // Two-stage synchronisers for the pins
      d.rst_s1 = reset_pin_in;
      d.rst_s2 = q.rst_s1;
      d.ms_s1  = debug_pin_in;
      d.ms_s2  = q.ms_s1;

      // APB: one wait state, answer on the second access cycle
      d.pready  = psel && penable && !q.pready;
      d.pslverr = 1'b0;
      if (psel && penable && !q.pready) begin
         d.pslverr = !mapped;
         d.prdata  = 32'h0;
         case (ofs)
            pin_mode_pkg::OFS_SYSTEM_OPTIONS_ONE: begin
               d.prdata[pin_mode_pkg::BIT_RESET_PIN_SELECT] = q.reset_pin_select;
               d.prdata[pin_mode_pkg::BIT_DEBUG_PIN_SELECT] = q.debug_pin_select;
            end
            pin_mode_pkg::OFS_CLOCK_CTRL_REG_TWO: begin
               d.prdata[pin_mode_pkg::BIT_OSC_RANGE]     = q.osc_range;
               d.prdata[pin_mode_pkg::BIT_OSC_EXT_CLOCK] = q.osc_ext_clock;
               d.prdata[pin_mode_pkg::BIT_BUS_DIV_LO +: 2] = q.bus_div;
            end
            pin_mode_pkg::OFS_MODE_STATUS: begin
               d.prdata[pin_mode_pkg::BIT_STAT_HALTED]      = q.halted;
               d.prdata[pin_mode_pkg::BIT_STAT_RESET_PIN]   = q.reset_pin_select;
               d.prdata[pin_mode_pkg::BIT_STAT_CAUSE_LO +: 2] = q.cause;
            end
            default: d.prdata = 32'h0;
         endcase
      end else if (!psel) begin
         d.prdata = 32'h0;
      end

      // Register writes, all on pclk; writes during internal reset are dropped
      if (wr_take) begin
         case (ofs)
            pin_mode_pkg::OFS_SYSTEM_OPTIONS_ONE: begin
               // Set-only: the reset function can be left only by power-on reset
               if (pwdata[pin_mode_pkg::BIT_RESET_PIN_SELECT])
                  d.reset_pin_select = 1'b1;
               d.debug_pin_select = pwdata[pin_mode_pkg::BIT_DEBUG_PIN_SELECT];
            end
            pin_mode_pkg::OFS_CLOCK_CTRL_REG_TWO: begin
               d.osc_range     = pwdata[pin_mode_pkg::BIT_OSC_RANGE];
               d.osc_ext_clock = pwdata[pin_mode_pkg::BIT_OSC_EXT_CLOCK];
               d.bus_div       = pwdata[pin_mode_pkg::BIT_BUS_DIV_LO +: 2];
            end
            default: d.bus_div = d.bus_div;
         endcase
      end

      // Starting an internal reset: pin first, then software force
      if (!q.in_reset) begin
         if (q.reset_pin_select && !q.rst_s2) begin
            d.in_reset = 1'b1;
            d.cause    = pin_mode_pkg::cause_pin;
            d.hold_cnt = 4'h0;
         end else if (wr_take && ofs == pin_mode_pkg::OFS_DEBUG_FORCE_RESET_REG &&
                      pwdata[pin_mode_pkg::BIT_DEBUG_FORCE_RESET]) begin
            d.in_reset = 1'b1;
            d.cause    = pin_mode_pkg::cause_force;
            d.hold_cnt = 4'h0;
         end
      end else begin
         // Held in reset: defaults reload, reset pin choice survives
         d.debug_pin_select = pin_mode_pkg::DEBUG_PIN_SELECT_RST;
         d.osc_range        = pin_mode_pkg::OSC_RANGE_RST;
         d.osc_ext_clock    = pin_mode_pkg::OSC_EXT_CLOCK_RST;
         d.bus_div          = pin_mode_pkg::BUS_DIV_DEFAULT;
         d.tx_state         = pin_mode_pkg::tx_idle;
         d.hold_cnt         = q.hold_cnt + 4'h1;
         // Pin reset stretches while the pin stays low
         if (q.cause == pin_mode_pkg::cause_pin && !q.rst_s2)
            d.hold_cnt = 4'h0;
         if (q.hold_cnt == pin_mode_pkg::RESET_HOLD_CYCLES - 4'h1) begin
            d.in_reset = 1'b0;
            // Mode sampled once at release; the pin reset never halts
            d.halted = (q.cause != pin_mode_pkg::cause_pin) && !q.ms_s2;
         end
      end
      d.sys_reset_n = !d.in_reset;

      // Pin function outputs
      d.rst_pin_pullup = d.reset_pin_select;
      // Pullup stays on through internal reset so a floating mode pin reads high
      d.dbg_pin_pullup = d.debug_pin_select;
      d.alt_fn_enable  = !d.debug_pin_select && !d.in_reset;

      // Debug wire bit transmit, counted in pclk (the fastest bus clock)
      d.tx_busy = 1'b0;
      d.dbg_oe  = 1'b0;
      d.dbg_out = 1'b0;
      if (!d.in_reset) begin
         case (q.tx_state)
            pin_mode_pkg::tx_idle: begin
               if (dbg_tx_start && q.debug_pin_select) begin
                  d.tx_state = pin_mode_pkg::tx_low;
                  d.bit_cnt  = 5'h0;
                  d.low_len  = dbg_tx_bit ? pin_mode_pkg::LOW_CYCLES_ONE
                                          : pin_mode_pkg::LOW_CYCLES_ZERO;
               end
            end
            pin_mode_pkg::tx_low: begin
               d.bit_cnt = q.bit_cnt + 5'h1;
               if (q.bit_cnt == q.low_len - 5'h1)
                  d.tx_state = pin_mode_pkg::tx_speedup;
            end
            pin_mode_pkg::tx_speedup: begin
               // One driven-high cycle sharpens the rising edge
               d.bit_cnt  = q.bit_cnt + 5'h1;
               d.tx_state = pin_mode_pkg::tx_release;
            end
            pin_mode_pkg::tx_release: begin
               d.bit_cnt = q.bit_cnt + 5'h1;
               if (q.bit_cnt == pin_mode_pkg::BIT_CYCLES - 5'h1)
                  d.tx_state = pin_mode_pkg::tx_idle;
            end
            default: d.tx_state = pin_mode_pkg::tx_idle;
         endcase
         d.tx_busy = d.tx_state != pin_mode_pkg::tx_idle;
         d.dbg_oe  = d.tx_state == pin_mode_pkg::tx_low ||
                     d.tx_state == pin_mode_pkg::tx_speedup;
         d.dbg_out = d.tx_state == pin_mode_pkg::tx_speedup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q                  <= '0;
         q.rst_s1           <= 1'b1;
         q.rst_s2           <= 1'b1;
         q.ms_s1            <= 1'b1;
         q.ms_s2            <= 1'b1;
         q.reset_pin_select <= pin_mode_pkg::RESET_PIN_SELECT_RST;
         q.debug_pin_select <= pin_mode_pkg::DEBUG_PIN_SELECT_RST;
         q.dbg_pin_pullup   <= pin_mode_pkg::DEBUG_PIN_SELECT_RST;
         q.osc_range        <= pin_mode_pkg::OSC_RANGE_RST;
         q.osc_ext_clock    <= pin_mode_pkg::OSC_EXT_CLOCK_RST;
         q.bus_div          <= pin_mode_pkg::BUS_DIV_DEFAULT;
         q.in_reset         <= 1'b1;
         q.cause            <= pin_mode_pkg::cause_por;
         q.tx_state         <= pin_mode_pkg::tx_idle;
      end else begin
         q <= d;
      end
   end

   assign pready                     = q.pready;
   assign prdata                     = q.prdata;
   assign pslverr                    = q.pslverr;
   assign reset_pin_pullup           = q.rst_pin_pullup;
   assign debug_pin_out              = q.dbg_out;
   assign debug_pin_oe               = q.dbg_oe;
   assign debug_pin_pullup           = q.dbg_pin_pullup;
   assign port_a_bit_four_alt_enable = q.alt_fn_enable;
   assign dbg_tx_busy                = q.tx_busy;
   assign sys_reset_n                = q.sys_reset_n;
   assign halted_debug_state         = q.halted;
   assign osc_range                  = q.osc_range;
   assign osc_ext_clock              = q.osc_ext_clock;
   assign bus_div                    = q.bus_div;

   logic debug_pin_select_chk;
   assign debug_pin_select_chk = q.debug_pin_select;

   a_rst_sel_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      q.reset_pin_select |=> q.reset_pin_select)
      else $error("reset pin select cleared without power-on");
   a_pin_reset_user: assert property (@(posedge pclk) disable iff (!presetn)
      (q.in_reset && q.cause == pin_mode_pkg::cause_pin) |-> ##[1:300] !halted_debug_state)
      else $error("pin reset left device halted");
   a_force_reset_go: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_take && ofs == pin_mode_pkg::OFS_DEBUG_FORCE_RESET_REG && pwdata[0] && !q.in_reset)
      |=> !sys_reset_n [*8])
      else $error("force reset not held eight cycles");
   a_dbg_in_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !sys_reset_n |-> !debug_pin_oe)
      else $error("debug pin driven during reset");
   a_dbg_sel_set: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sys_reset_n) |-> debug_pin_select_chk)
      else $error("debug pin select not set after reset");
   a_bit_time_len: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(dbg_tx_busy) && sys_reset_n) |-> dbg_tx_busy [*8] ##1 dbg_tx_busy [*8]
      ##1 !dbg_tx_busy)
      else $error("debug bit time wrong");
   a_speedup_short: assert property (@(posedge pclk) disable iff (!presetn)
      (debug_pin_oe && debug_pin_out) |=> !debug_pin_oe)
      else $error("speedup pulse longer than one cycle");
   a_clock_default: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sys_reset_n) |-> (bus_div == pin_mode_pkg::BUS_DIV_DEFAULT && !osc_ext_clock))
      else $error("clock not at default after reset");
   a_pin_pullup: assert property (@(posedge pclk) disable iff (!presetn)
      q.reset_pin_select |=> reset_pin_pullup)
      else $error("reset pin pullup not enabled");

   c_pin_reset: cover property (@(posedge pclk) disable iff (!presetn)
      q.in_reset && q.cause == pin_mode_pkg::cause_pin);
   c_force_halt: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(halted_debug_state) && q.cause == pin_mode_pkg::cause_force);
   c_bit_sent: cover property (@(posedge pclk) disable iff (!presetn)
      $fell(dbg_tx_busy) && sys_reset_n);
endmodule : reset_and_mode_pin_control

// *** verif/reset_debug_host.sv ***
// Model of the external reset source and the single-wire debug host
`timescale 1ns/1ns
module reset_debug_host (
   // Clock
   input  wire logic       pclk,
   // Commands from the bench
   input  wire logic [1:0] rst_mode,
   input  wire logic       ms_low,
   // Device pin controls
   input  wire logic       reset_pin_pullup,
   input  wire logic       debug_pin_out,
   input  wire logic       debug_pin_oe,
   input  wire logic       debug_pin_pullup,
   // Resolved pin levels
   output logic            reset_pin_in,
   output logic            debug_pin_in
);
   logic rst_last = 1'b0;
   logic dbg_last = 1'b0;
   // Unpulled open lines show a changing level so a stale value never passes
   always_ff @(posedge pclk) begin
      rst_last <= reset_pin_in;
      dbg_last <= debug_pin_in;
   end
   always_comb begin
      // Source drives low to reset, drives high to stay quiet, or lets go
      case (rst_mode)
         2'h1: reset_pin_in = 1'b0;
         2'h2: reset_pin_in = 1'b1;
         default: reset_pin_in = reset_pin_pullup ? 1'b1 : ~rst_last;
      endcase
      // Device speedup pulse wins; host pulls low to ask for halted entry
      if (debug_pin_oe === 1'b1) begin
         debug_pin_in = debug_pin_out;
      end else if (ms_low) begin
         debug_pin_in = 1'b0;
      end else begin
         debug_pin_in = debug_pin_pullup ? 1'b1 : ~dbg_last;
      end
   end
endmodule : reset_debug_host

// *** verif/reset_and_mode_pin_control_test.sv ***
// Self-checking bench for the reset and mode pin control block
`timescale 1ns/1ns
module reset_and_mode_pin_control_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic        reset_pin_in, reset_pin_pullup, debug_pin_in, debug_pin_out, debug_pin_oe;
   logic        debug_pin_pullup, port_a_bit_four_alt_enable, dbg_tx_start, dbg_tx_bit;
   logic        dbg_tx_busy, sys_reset_n, halted_debug_state, osc_range, osc_ext_clock;
   logic        ms_low, b;
   logic [1:0]  bus_div, rst_mode;
   int          bad_count, samples_checked, cyc, seed, n_busy, n_low, n_high, exp_opt;

   reset_and_mode_pin_control reset_and_mode_pin_control_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .reset_pin_in, .reset_pin_pullup,
      .debug_pin_in, .debug_pin_out, .debug_pin_oe, .debug_pin_pullup,
      .port_a_bit_four_alt_enable, .dbg_tx_start, .dbg_tx_bit, .dbg_tx_busy, .sys_reset_n,
      .halted_debug_state, .osc_range, .osc_ext_clock, .bus_div);
   reset_debug_host reset_debug_host_i (.pclk, .rst_mode, .ms_low, .reset_pin_pullup,
      .debug_pin_out, .debug_pin_oe, .debug_pin_pullup, .reset_pin_in, .debug_pin_in);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task complete_run;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   // Cut a hang short; the whole sequence needs well under 3000 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; waits for pready however long the slave takes
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      chk(pready, 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rchk

   task wait_rst(input logic v);
      int k;
      k = 0;
      while (sys_reset_n !== v && k < 200) begin
         @(posedge pclk);
         k++;
      end
      chk(sys_reset_n, v);
   endtask : wait_rst

   // Model of options and status, compared with registers and pin controls
   task state_chk(input logic h, input int cause);
      rchk(8'h00, exp_opt);
      rchk(8'h0C, h | (exp_opt & 1) << 1 | cause << 2);
      chk(halted_debug_state, h);
      chk(reset_pin_pullup, exp_opt & 1);
      chk(debug_pin_pullup, exp_opt >> 1 & 1);
      chk(port_a_bit_four_alt_enable, ~exp_opt >> 1 & 1);
   endtask : state_chk

   task por(input logic low);
      ms_low  <= low;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(debug_pin_oe, 1'b0);
      presetn <= 1'b1;
      wait_rst(1'b1);
      ms_low <= 1'b0;
      exp_opt = 2;
   endtask : por

   // Sends one bit and counts busy, driven-low and speedup cycles
   task tx(input logic bv);
      @(posedge pclk);
      dbg_tx_start <= 1'b1;
      dbg_tx_bit   <= bv;
      @(posedge pclk);
      dbg_tx_start <= 1'b0;
      n_busy = 0;
      n_low = 0;
      n_high = 0;
      repeat (20) begin
         @(posedge pclk);
         n_busy += (dbg_tx_busy === 1'b1);
         n_low += (debug_pin_oe === 1'b1 && debug_pin_out === 1'b0);
         n_high += (debug_pin_oe === 1'b1 && debug_pin_out === 1'b1);
      end
   endtask : tx

   initial begin
      {presetn, psel, penable, pwrite, dbg_tx_start, dbg_tx_bit, ms_low} = '0;
      {paddr, pwdata, rst_mode} = '0;
      {bad_count, samples_checked, cyc} = '0;
      seed = 90423;
      por(1'b0);
      state_chk(1'b0, 0);
      rchk(8'h08, 32'h4);
      chk({osc_ext_clock, osc_range, bus_div}, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      rst_mode <= 2'h1;
      repeat (20) begin
         @(posedge pclk);
         chk(sys_reset_n, 1'b1);
      end
      rst_mode <= 2'h2;
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         apb(1'b1, 8'h08, d);
         rchk(8'h08, d & 32'hF);
         chk({osc_ext_clock, osc_range, bus_div}, {d[1:0], d[3:2]});
      end
      for (int i = 0; i < 6; i++) begin
         b = 1'($random(seed));
         tx(b);
         chk(n_busy, 16);
         chk(n_low, b ? 4 : 13);
         chk(n_high, 1);
      end
      apb(1'b1, 8'h00, 32'h0);
      exp_opt = 0;
      state_chk(1'b0, 0);
      tx(1'b1);
      chk(n_busy + n_low, 0);
      por(1'b1);
      state_chk(1'b1, 0);
      apb(1'b1, 8'h00, 32'h1);
      exp_opt = 1;
      state_chk(1'b1, 0);
      ms_low   <= 1'b1;
      rst_mode <= 2'h1;
      wait_rst(1'b0);
      repeat (10) @(posedge pclk);
      rst_mode <= 2'h2;
      wait_rst(1'b1);
      exp_opt = 3;
      state_chk(1'b0, 1);
      apb(1'b1, 8'h04, 32'h1);
      wait_rst(1'b0);
      chk(debug_pin_oe, 1'b0);
      wait_rst(1'b1);
      ms_low <= 1'b0;
      state_chk(1'b1, 2);
      por(1'b0);
      state_chk(1'b0, 0);
      complete_run();
   end
endmodule : reset_and_mode_pin_control_test
